// ### rtl/vga_pd_pkg.sv
`default_nettype none
package vga_pd_pkg;

   typedef enum logic [2:0] {
      ST_NORMAL,
      ST_SLEEP_ENTER,
      ST_SLEEP_OFF,
      ST_SLEEP_EXIT,
      ST_IDLE,
      ST_GPD_EXT,
      ST_GPD_INT
   } pd_state_e;

   // register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 8;
   localparam logic [3:0] ADDR_CFG_SLEEP = 4'h0;
   localparam logic [3:0] ADDR_CFG_GPD   = 4'h1;
   localparam logic [3:0] ADDR_CFG_RPL   = 4'h2;
   localparam logic [3:0] ADDR_STATUS    = 4'h3;

   // field positions
   localparam int SLEEP_SEL_BIT  = 7;
   localparam int INT_DIV_BIT    = 6;
   localparam int GPD_SEL_BIT    = 7;
   localparam int PD_COUNT_LSB   = 0;
   localparam int PD_COUNT_W     = 7;
   localparam int RPL_LSB        = 0;
   localparam int RPL_W          = 2;
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_CLKOFF    = 3;
   localparam int STAT_REQ_N     = 4;

   // reset values
   localparam logic       SLEEP_SEL_RST = 1'b0;
   localparam logic       INT_DIV_RST   = 1'b0;
   localparam logic       GPD_SEL_RST   = 1'b0;
   localparam logic [6:0] PD_COUNT_RST  = 7'h00;
   localparam logic [1:0] RPL_RST       = 2'h0;

   // timing counts
   localparam int WAIT_LINES     = 4;
   localparam int WAIT_REFRESHES = 3;
   localparam int CLK_DIV        = 8;
   localparam int CHAR_CLOCKS    = 8;
   localparam logic [7:0] PD_COUNT_BIAS    = 8'h05;
   localparam logic [1:0] RPL_TWO_PER_LINE = 2'h3;

endpackage
`default_nettype wire

// ### rtl/clock_gate_divider.sv
`timescale 1ns/10ps
`default_nettype none
module clock_gate_divider
   import vga_pd_pkg::*;
#(
   parameter int DIV = CLK_DIV
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic run,
   input  wire logic divide,
   output logic      video_clock_in_en,
   output logic      mclk_en
);

   localparam int CW = $clog2(DIV);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          ven;
      logic          men;
   } div_s;

   div_s r_reg;
   div_s r_next;

   always_comb begin
      r_next = r_reg;
      if (ce) begin
         if (!run) begin
            r_next.cnt = '0;
            r_next.ven = 1'b0;
            r_next.men = 1'b0;
         end else if (divide) begin
            r_next.cnt = (r_reg.cnt == CW'(DIV - 1)) ? '0 : r_reg.cnt + 1'b1;
            r_next.ven = (r_reg.cnt == CW'(DIV - 1));
            r_next.men = (r_reg.cnt == CW'(DIV - 1));
         end else begin
            r_next.cnt = '0;
            r_next.ven = 1'b1;
            r_next.men = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign video_clock_in_en = r_reg.ven;
   assign mclk_en = r_reg.men;

endmodule
`default_nettype wire

// ### rtl/line_refresh_timer.sv
`timescale 1ns/10ps
`default_nettype none
module line_refresh_timer
   import vga_pd_pkg::*;
#(
   parameter int LINES     = WAIT_LINES,
   parameter int REFRESHES = WAIT_REFRESHES
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic ce,
   input  wire logic start,
   input  wire logic line_tick,
   input  wire logic refresh_tick,
   output logic      done
);

   localparam int CW = 4;

   typedef struct packed {
      logic [CW-1:0] lines;
      logic [CW-1:0] refs;
      logic          done;
   } tmr_s;

   tmr_s r_reg;
   tmr_s r_next;

   always_comb begin
      r_next = r_reg;
      if (ce) begin
         if (start) begin
            r_next = '0;
         end else if (!r_reg.done) begin
            // lines first, then refresh requests
            if (r_reg.lines != CW'(LINES)) begin
               if (line_tick) r_next.lines = r_reg.lines + 1'b1;
            end else if (r_reg.refs != CW'(REFRESHES)) begin
               if (refresh_tick) r_next.refs = r_reg.refs + 1'b1;
            end else begin
               r_next.done = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign done = r_reg.done;

endmodule
`default_nettype wire

// ### rtl/vga_power_down_sequencer.sv
// Strobed register access and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module vga_power_down_sequencer
   import vga_pd_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              arst_n,
   input  wire logic              ce,
   input  wire logic              power_down_request_n,
   input  wire logic              line_tick,
   input  wire logic              refresh_request,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic       [DATA_W-1:0] reg_rdata,
   output logic                    io_access_allow,
   output logic                    mem_access_allow,
   output logic                    display_on,
   output logic                    dac_power_on,
   output logic                    screen_fetch_on,
   output logic                    dram_drive_high,
   output logic                    cbr_refresh_cycle,
   output logic                    ras_refresh_cycle,
   output logic                    video_clock_in_en,
   output logic                    mclk_en
);

   typedef struct packed {
      pd_state_e                 st;
      logic                      sleep_sel;
      logic                      int_div;
      logic                      gpd_sel;
      logic [PD_COUNT_W-1:0]     pd_count;
      logic [RPL_W-1:0]          rpl;
      logic                      start;
      logic [1:0]                pend;
      logic [2:0]                presc;
      logic [7:0]                chars;
      logic [DATA_W-1:0]         rdata;
      logic                      io;
      logic                      mem;
      logic                      disp;
      logic                      dac;
      logic                      fetch;
      logic                      dram_high;
      logic                      cbr;
      logic                      ras;
   } seq_s;

   seq_s r_reg;
   seq_s r_next;

   logic       timer_done;
   logic       clk_run;
   logic       clk_div;
   logic [1:0] rpl_count;
   logic       cur_sleep;
   logic       nxt_sleep;
   logic       nxt_gpd;
   logic       refresh_load;

   always_comb begin
      r_next       = r_reg;
      rpl_count    = (r_reg.rpl == RPL_TWO_PER_LINE) ? 2'h2 : 2'h1;
      cur_sleep    = (r_reg.st == ST_SLEEP_ENTER) ||
                     (r_reg.st == ST_SLEEP_OFF) ||
                     (r_reg.st == ST_SLEEP_EXIT);
      nxt_sleep    = 1'b0;
      nxt_gpd      = 1'b0;
      refresh_load = 1'b0;
      if (ce) begin
         r_next.start = 1'b0;
         r_next.rdata = '0;
         r_next.cbr   = 1'b0;
         r_next.ras   = 1'b0;
         // register port
         if (reg_wr) begin
            case (reg_addr)
               ADDR_CFG_SLEEP: begin
                  r_next.sleep_sel = reg_wdata[SLEEP_SEL_BIT];
                  r_next.int_div   = reg_wdata[INT_DIV_BIT];
               end
               ADDR_CFG_GPD: begin
                  r_next.gpd_sel  = reg_wdata[GPD_SEL_BIT];
                  r_next.pd_count =
                     reg_wdata[PD_COUNT_LSB +: PD_COUNT_W];
               end
               ADDR_CFG_RPL: begin
                  r_next.rpl = reg_wdata[RPL_LSB +: RPL_W];
               end
               default: begin
               end
            endcase
         end
         if (reg_rd) begin
            case (reg_addr)
               ADDR_CFG_SLEEP: begin
                  r_next.rdata[SLEEP_SEL_BIT] = r_reg.sleep_sel;
                  r_next.rdata[INT_DIV_BIT]   = r_reg.int_div;
               end
               ADDR_CFG_GPD: begin
                  r_next.rdata[GPD_SEL_BIT] = r_reg.gpd_sel;
                  r_next.rdata[PD_COUNT_LSB +: PD_COUNT_W] = r_reg.pd_count;
               end
               ADDR_CFG_RPL: begin
                  r_next.rdata[RPL_LSB +: RPL_W] = r_reg.rpl;
               end
               ADDR_STATUS: begin
                  r_next.rdata[STAT_STATE_LSB +: 3] = r_reg.st;
                  r_next.rdata[STAT_CLKOFF] = (r_reg.st == ST_SLEEP_OFF);
                  r_next.rdata[STAT_REQ_N]  = power_down_request_n;
               end
               default: begin
                  r_next.rdata = '0;
               end
            endcase
         end
         // mode sequencing
         case (r_reg.st)
            ST_NORMAL: begin
               if (!power_down_request_n) begin
                  if (r_reg.sleep_sel) begin
                     r_next.st    = ST_SLEEP_ENTER;
                     r_next.start = 1'b1;
                  end else if (r_reg.gpd_sel) begin
                     r_next.st = r_reg.int_div ? ST_GPD_INT
                                               : ST_GPD_EXT;
                  end else begin
                     r_next.st = ST_IDLE;
                  end
               end
            end
            ST_SLEEP_ENTER: begin
               if (!r_reg.start && timer_done) begin
                  r_next.st = ST_SLEEP_OFF;
               end
            end
            ST_SLEEP_OFF: begin
               if (power_down_request_n) begin
                  r_next.st    = ST_SLEEP_EXIT;
                  r_next.start = 1'b1;
               end
            end
            ST_SLEEP_EXIT: begin
               if (!r_reg.start && timer_done) begin
                  r_next.st = ST_NORMAL;
               end
            end
            ST_IDLE, ST_GPD_EXT, ST_GPD_INT: begin
               if (power_down_request_n) begin
                  r_next.st = ST_NORMAL;
               end
            end
            default: begin
               r_next.st = ST_NORMAL;
            end
         endcase
         nxt_sleep = (r_next.st == ST_SLEEP_ENTER) ||
                     (r_next.st == ST_SLEEP_OFF) ||
                     (r_next.st == ST_SLEEP_EXIT);
         nxt_gpd   = (r_next.st == ST_GPD_EXT) || (r_next.st == ST_GPD_INT);
         // host access and display outputs
         r_next.io        = !nxt_sleep;
         r_next.mem       = (r_next.st == ST_NORMAL) || nxt_gpd;
         r_next.disp      = (r_next.st == ST_NORMAL);
         r_next.dac       = (r_next.st == ST_NORMAL);
         r_next.fetch     = (r_next.st == ST_NORMAL) || nxt_gpd;
         r_next.dram_high = nxt_sleep;
         // CAS-before-RAS from refresh request
         if ((cur_sleep || r_reg.st == ST_IDLE) && refresh_request) begin
            r_next.cbr = 1'b1;
         end
         // RAS-only refresh timing
         if (r_reg.st == ST_NORMAL) begin
            refresh_load  = line_tick;
            r_next.presc  = '0;
            r_next.chars  = '0;
         end else if (r_reg.st == ST_GPD_EXT || r_reg.st == ST_GPD_INT) begin
            if (video_clock_in_en) begin
               r_next.presc = r_reg.presc + 1'b1;
               if (r_reg.presc == 3'(CHAR_CLOCKS - 1)) begin
                  // period is count plus bias characters
                  if (r_reg.chars + 8'h01 ==
                      {1'b0, r_reg.pd_count} + PD_COUNT_BIAS) begin
                     r_next.chars = '0;
                     refresh_load = 1'b1;
                  end else begin
                     r_next.chars = r_reg.chars + 1'b1;
                  end
               end
            end
         end else begin
            r_next.presc = '0;
            r_next.chars = '0;
         end
         if (cur_sleep || r_reg.st == ST_IDLE) begin
            r_next.pend = '0;
         end else if (refresh_load) begin
            r_next.pend = rpl_count;
         end else if (r_reg.pend != 2'h0) begin
            // no RAS-only cycle once a CBR mode is taken
            r_next.ras  = (r_next.st == ST_NORMAL) || nxt_gpd;
            r_next.pend = r_reg.pend - 1'b1;
         end
      end
   end

   assign clk_run = (r_next.st != ST_SLEEP_OFF);
   assign clk_div = (r_next.st == ST_IDLE) ||
                    (r_next.st == ST_GPD_INT);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r_reg           <= '0;
         r_reg.st        <= ST_NORMAL;
         r_reg.sleep_sel <= SLEEP_SEL_RST;
         r_reg.int_div   <= INT_DIV_RST;
         r_reg.gpd_sel   <= GPD_SEL_RST;
         r_reg.pd_count  <= PD_COUNT_RST;
         r_reg.rpl       <= RPL_RST;
         r_reg.io        <= 1'b1;
         r_reg.mem       <= 1'b1;
         r_reg.disp      <= 1'b1;
         r_reg.dac       <= 1'b1;
         r_reg.fetch     <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   line_refresh_timer u_timer (
      .clk          (clk),
      .arst_n       (arst_n),
      .ce           (ce),
      .start        (r_reg.start),
      .line_tick    (line_tick),
      .refresh_tick (refresh_request),
      .done         (timer_done)
   );

   clock_gate_divider u_clk (
      .clk     (clk),
      .arst_n  (arst_n),
      .ce      (ce),
      .run     (clk_run),
      .divide  (clk_div),
      .video_clock_in_en (video_clock_in_en),
      .mclk_en (mclk_en)
   );

   assign reg_rdata         = r_reg.rdata;
   assign io_access_allow   = r_reg.io;
   assign mem_access_allow  = r_reg.mem;
   assign display_on        = r_reg.disp;
   assign dac_power_on      = r_reg.dac;
   assign screen_fetch_on   = r_reg.fetch;
   assign dram_drive_high   = r_reg.dram_high;
   assign cbr_refresh_cycle = r_reg.cbr;
   assign ras_refresh_cycle = r_reg.ras;

   // checks
   property p_sleep_enter;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_NORMAL && !power_down_request_n &&
       r_reg.sleep_sel) |=> (r_reg.st == ST_SLEEP_ENTER);
   endproperty
   a_sleep_enter: assert property (p_sleep_enter)
      else $error("sleep not entered");

   property p_sleep_block;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_NORMAL && !power_down_request_n &&
       r_reg.sleep_sel) |=> (!io_access_allow && !mem_access_allow);
   endproperty
   a_sleep_block: assert property (p_sleep_block)
      else $error("host access not refused in sleep");

   property p_clock_stop;
      @(posedge clk) disable iff (!arst_n)
      (r_reg.st == ST_SLEEP_OFF) |-> (!video_clock_in_en && !mclk_en && timer_done);
   endproperty
   a_clock_stop: assert property (p_clock_stop)
      else $error("clocks running in sleep");

   property p_cbr;
      @(posedge clk) disable iff (!arst_n)
      (ce && cur_sleep && refresh_request) |=> cbr_refresh_cycle;
   endproperty
   a_cbr: assert property (p_cbr)
      else $error("refresh request gave no CBR cycle");

   property p_sleep_outputs;
      @(posedge clk) disable iff (!arst_n)
      cur_sleep |-> (dram_drive_high && !display_on && !dac_power_on &&
                     !ras_refresh_cycle);
   endproperty
   a_sleep_outputs: assert property (p_sleep_outputs)
      else $error("sleep outputs wrong");

   property p_idle_div;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_IDLE && !power_down_request_n && video_clock_in_en)
      |=> !video_clock_in_en;
   endproperty
   a_idle_div: assert property (p_idle_div)
      else $error("idle clock not divided");

   property p_idle_access;
      @(posedge clk) disable iff (!arst_n)
      (r_reg.st == ST_IDLE) |-> (io_access_allow && !mem_access_allow &&
                                 !screen_fetch_on && !dac_power_on);
   endproperty
   a_idle_access: assert property (p_idle_access)
      else $error("idle access wrong");

   property p_idle_exit;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_IDLE && power_down_request_n)
      |=> (r_reg.st == ST_NORMAL && display_on);
   endproperty
   a_idle_exit: assert property (p_idle_exit)
      else $error("idle exit not immediate");

   property p_gpd_access;
      @(posedge clk) disable iff (!arst_n)
      (r_reg.st == ST_GPD_EXT || r_reg.st == ST_GPD_INT)
      |-> (io_access_allow && mem_access_allow && !display_on &&
           !dac_power_on);
   endproperty
   a_gpd_access: assert property (p_gpd_access)
      else $error("general power-down outputs wrong");

   property p_idle_select;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_NORMAL && !power_down_request_n &&
       !r_reg.sleep_sel && !r_reg.gpd_sel) |=> (r_reg.st == ST_IDLE);
   endproperty
   a_idle_select: assert property (p_idle_select)
      else $error("idle not entered");

   property p_sleep_exit;
      @(posedge clk) disable iff (!arst_n)
      (ce && r_reg.st == ST_SLEEP_EXIT && !r_reg.start && timer_done)
      |=> (r_reg.st == ST_NORMAL && display_on);
   endproperty
   a_sleep_exit: assert property (p_sleep_exit)
      else $error("sleep exit wrong");

   c_sleep_off: cover property (@(posedge clk) r_reg.st == ST_SLEEP_OFF);
   c_idle: cover property (@(posedge clk) r_reg.st == ST_IDLE);
   c_gpd_int: cover property (@(posedge clk)
      r_reg.st == ST_GPD_INT && ras_refresh_cycle);
   c_sleep_back: cover property (@(posedge clk)
      r_reg.st == ST_SLEEP_EXIT ##1 r_reg.st == ST_NORMAL);

endmodule
`default_nettype wire

// ### testbench/power_manager_model.sv
`timescale 1ns/10ps
`default_nettype none
module power_manager_model (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic req_cmd_n,
   input  wire logic tick_en,
   output logic      power_down_request_n,
   output logic      line_tick,
   output logic      refresh_request
);
   logic [4:0] line_cnt;
   logic [4:0] ref_cnt;

   // clock inputs never slowed, so full rate whenever tick_en is high
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_down_request_n <= 1'b1;
         line_cnt             <= 5'h00;
         ref_cnt              <= 5'h00;
         line_tick            <= 1'b0;
         refresh_request      <= 1'b0;
      end else begin
         // request follows req_cmd_n one clock later, at any time
         power_down_request_n <= req_cmd_n;
         line_cnt <= (line_cnt == 5'h13) ? 5'h00 : line_cnt + 5'h01;
         ref_cnt  <= (ref_cnt == 5'h1D) ? 5'h00 : ref_cnt + 5'h01;
         line_tick       <= tick_en && (line_cnt == 5'h13);
         refresh_request <= tick_en && (ref_cnt == 5'h1D);
      end
   end
endmodule
`default_nettype wire

// ### testbench/vga_power_down_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module vga_power_down_sequencer_tb
   import vga_pd_pkg::*;
;
   logic              clk;
   logic              arst_n;
   logic              req_cmd_n;
   logic              tick_en;
   logic              pd_req_n;
   logic              line_tick;
   logic              refresh_request;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic              io_ok;
   logic              mem_ok;
   logic              disp;
   logic              dac;
   logic              fetch;
   logic              dhigh;
   logic              cbr;
   logic              ras;
   logic              video_clock_in_en;
   logic              mclk_en;
   int                fail_count;
   int                checks_done;
   int                nv;
   int                nc;
   int                nr;
   int                w;

   power_manager_model pm (.clk(clk), .arst_n(arst_n), .req_cmd_n(req_cmd_n),
      .tick_en(tick_en), .power_down_request_n(pd_req_n),
      .line_tick(line_tick), .refresh_request(refresh_request));

   vga_power_down_sequencer DUT (.clk(clk), .arst_n(arst_n), .ce(1'b1),
      .power_down_request_n(pd_req_n), .line_tick(line_tick),
      .refresh_request(refresh_request), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .io_access_allow(io_ok),
      .mem_access_allow(mem_ok), .display_on(disp), .dac_power_on(dac),
      .screen_fetch_on(fetch), .dram_drive_high(dhigh),
      .cbr_refresh_cycle(cbr), .ras_refresh_cycle(ras),
      .video_clock_in_en(video_clock_in_en), .mclk_en(mclk_en));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict;
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask

   task automatic rng(input int v, input int lo, input int hi);
      checks_done++;
      if (v < lo || v > hi) begin
         fail_count++;
         $display("BAD %0t count %0d outside %0d..%0d", $time, v, lo, hi);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
   endtask

   task automatic set_req(input logic v);
      @(posedge clk);
      req_cmd_n <= v;
      repeat (3) @(posedge clk);
      #1;
   endtask

   task automatic cnt(input int n);
      nv = 0;
      nc = 0;
      nr = 0;
      repeat (n) begin
         @(posedge clk);
         #1;
         if (video_clock_in_en === 1'b1 && mclk_en === 1'b1) nv++;
         if (cbr === 1'b1) nc++;
         if (ras === 1'b1) nr++;
      end
   endtask

   function automatic logic [7:0] flags();
      return {2'b00, io_ok, mem_ok, disp, dac, fetch, dhigh};
   endfunction

   task automatic sleep_cycle;
      set_req(1'b0);
      chk(flags(), 8'h01);
      w = 0;
      while (video_clock_in_en !== 1'b0 && w < 600) begin
         @(posedge clk);
         #1;
         w++;
      end
      rng(w, 60, 300);
      cnt(90);
      chk(8'(nv), 8'h00);
      rng(nc, 2, 4);
      chk(8'(nr), 8'h00);
      chk(flags(), 8'h01);
      set_req(1'b1);
      w = 0;
      while (io_ok !== 1'b1 && w < 600) begin
         @(posedge clk);
         #1;
         w++;
      end
      rng(w, 60, 300);
      chk(flags(), 8'h3E);
   endtask

   initial begin
      #(25 * 20000);
      fail_count++;
      give_verdict();
   end

   initial begin
      fail_count = 0;
      checks_done = 0;
      arst_n = 1'b0;
      req_cmd_n = 1'b1;
      tick_en = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      #1;
      chk(flags(), 8'h3E);
      rdc(ADDR_CFG_SLEEP, 8'h00);
      rdc(ADDR_STATUS, 8'h10);
      wr(ADDR_CFG_GPD, 8'hFF);
      wr(4'hA, 8'h55);
      rdc(ADDR_CFG_GPD, 8'hFF);
      rdc(4'hA, 8'h00);
      // refreshes per line in normal operation
      wr(ADDR_CFG_RPL, 8'h03);
      cnt(200);
      rng(nr, 18, 22);
      chk(8'(nc), 8'h00);
      wr(ADDR_CFG_RPL, 8'h00);
      cnt(200);
      rng(nr, 9, 11);
      // display idle
      wr(ADDR_CFG_GPD, 8'h00);
      wr(ADDR_CFG_SLEEP, 8'h40);
      set_req(1'b0);
      chk(flags(), 8'h20);
      rdc(ADDR_STATUS, 8'h04);
      cnt(16);
      chk(8'(nv), 8'h02);
      cnt(64);
      rng(nc, 2, 3);
      chk(8'(nr), 8'h00);
      set_req(1'b1);
      chk(flags(), 8'h3E);
      rdc(ADDR_STATUS, 8'h10);
      // general power-down, external clock
      wr(ADDR_CFG_SLEEP, 8'h00);
      wr(ADDR_CFG_GPD, 8'h81);
      tick_en <= 1'b0;
      set_req(1'b0);
      chk(flags(), 8'h32);
      rdc(ADDR_STATUS, 8'h05);
      cnt(480);
      rng(nv, 480, 480);
      rng(nr, 9, 11);
      set_req(1'b1);
      // general power-down, internal divide
      wr(ADDR_CFG_SLEEP, 8'h40);
      set_req(1'b0);
      chk(flags(), 8'h32);
      rdc(ADDR_STATUS, 8'h06);
      cnt(400);
      rng(nv, 50, 50);
      rng(nr, 1, 1);
      set_req(1'b1);
      tick_en <= 1'b1;
      // sleep wins over the other mode bits
      wr(ADDR_CFG_SLEEP, 8'hC0);
      sleep_cycle();
      wr(ADDR_CFG_GPD, 8'h00);
      wr(ADDR_CFG_SLEEP, 8'h80);
      sleep_cycle();
      rdc(ADDR_STATUS, 8'h10);
      give_verdict();
   end
endmodule
`default_nettype wire
